// >>> hdl/ccms_clock_select.sv
// CPU clock generation mode selection with APB register access
//
// Notes on behaviour
// - Both CPU clock edges time operations; one half period is the basic unit.
// - Clock mode comes from bits 7..5 of the upper reset configuration register.
// - Long hardware reset loads that register from the upper port 0 pins.
// - Software may reload it from the upper half of the reset control register.
// - Field decodes to x4,x3,x2,x5,direct,x1.5,div2,x2.5 from 111 down to 000.
// - Prescaler mode halves the oscillator; each half period is one oscillator period.
// - PLL modes enable the PLL with the factor, resynchronising every factor-th edge.
// - Direct mode disables the PLL and follows the oscillator duty cycle.
// - In direct mode two consecutive half periods equal one oscillator period.
// - Pin for the field MSB is inverted in emulation and emulation hold mode.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ccms_clock_select #(
    parameter int LONG_RESET_CYCLES = ccms_pkg::LONG_RESET_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        hw_reset_in,
    input  wire logic        emulation_mode_in,
    input  wire logic        emulation_hold_mode_in,
    input  wire logic [7:0]  port0_upper_pins_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [2:0]       clock_gen_select_out,
    output logic             pll_enable_out,
    output logic [3:0]       pll_mult_x2_out,
    output logic             prescale_out,
    output logic             direct_drive_out,
    output logic             cpu_clk_phase_out
);
    import ccms_pkg::*;

    logic [7:0]  reset_pin_config_upper;
    logic [15:0] reset_control_reg;
    logic [15:0] long_cnt;
    logic        long_reset;
    logic        reload_req;
    logic        setup;
    logic        wr_access;
    logic        rd_access;
    logic [31:0] next_prdata;
    logic        addr_ok;
    logic [7:0]  pin_view;

    // Multiplier factor times two per field code
    function automatic logic [3:0] mult_x2(input logic [2:0] code);
        logic [3:0] f;
        f = 4'h0;
        unique case (code)
            MODE_X4:       f = 4'h8;
            MODE_X3:       f = 4'h6;
            MODE_X2:       f = 4'h4;
            MODE_X5:       f = 4'hA;
            MODE_DIRECT:   f = 4'h2;
            MODE_X1P5:     f = 4'h3;
            MODE_PRESCALE: f = 4'h1;
            MODE_X2P5:     f = 4'h5;
        endcase
        return f;
    endfunction : mult_x2

    function automatic ccms_path_e path_of(input logic [2:0] code);
        if (code == MODE_PRESCALE) begin
            return CCMS_PRESCALE;
        end else if (code == MODE_DIRECT) begin
            return CCMS_DIRECT;
        end
        return CCMS_PLL;
    endfunction : path_of

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    assign addr_ok   = (paddr[7:0] == ADDR_CFG_UPPER) || (paddr[7:0] == ADDR_RST_CTRL)
                       || (paddr[7:0] == ADDR_STATUS);
    assign reload_req = wr_access && (paddr[7:0] == ADDR_RST_CTRL) && pwdata[RELOAD_BIT];

    // Emulation flips the pin carrying the field MSB
    always_comb begin
        pin_view = port0_upper_pins_in;
        pin_view[CLK_FIELD_MSB] = port0_upper_pins_in[CLK_FIELD_MSB]
                                  ^ (emulation_mode_in | emulation_hold_mode_in);
    end

    // Long reset is a hardware reset held at least the qualifying time
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            long_cnt   <= 16'h0000;
            long_reset <= 1'b0;
        end else if (hw_reset_in) begin
            if (long_cnt < 16'(LONG_RESET_CYCLES)) begin
                long_cnt <= long_cnt + 16'h0001;
            end
            long_reset <= (long_cnt >= 16'(LONG_RESET_CYCLES - 1));
        end else begin
            long_cnt   <= 16'h0000;
            long_reset <= 1'b0;
        end
    end

    // Configuration register: pins during long reset, else software reload
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reset_pin_config_upper <= CFG_RESET_VALUE;
        end else if (long_reset) begin
            reset_pin_config_upper <= pin_view;
        end else if (reload_req) begin
            reset_pin_config_upper <= reset_control_reg[RST_CTRL_UP_LSB +: 8];
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reset_control_reg <= RST_CTRL_RESET;
        end else if (wr_access && paddr[7:0] == ADDR_RST_CTRL) begin
            reset_control_reg <= {pwdata[15:1], 1'b0};
        end
    end

    // Mode decode registered onto outputs
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clock_gen_select_out <= CFG_RESET_VALUE[CLK_FIELD_MSB:CLK_FIELD_LSB];
            pll_enable_out       <= 1'b1;
            pll_mult_x2_out      <= 4'h8;
            prescale_out         <= 1'b0;
            direct_drive_out     <= 1'b0;
        end else begin
            clock_gen_select_out <= reset_pin_config_upper[CLK_FIELD_MSB:CLK_FIELD_LSB];
            pll_mult_x2_out <= mult_x2(reset_pin_config_upper[CLK_FIELD_MSB:CLK_FIELD_LSB]);
            pll_enable_out <= path_of(reset_pin_config_upper[CLK_FIELD_MSB:CLK_FIELD_LSB])
                              == CCMS_PLL;
            prescale_out <= path_of(reset_pin_config_upper[CLK_FIELD_MSB:CLK_FIELD_LSB])
                            == CCMS_PRESCALE;
            direct_drive_out <= path_of(reset_pin_config_upper[CLK_FIELD_MSB:CLK_FIELD_LSB])
                                == CCMS_DIRECT;
        end
    end

    // Prescaler phase: toggles each oscillator period so each half period is one period
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cpu_clk_phase_out <= 1'b0;
        end else if (prescale_out) begin
            cpu_clk_phase_out <= !cpu_clk_phase_out;
        end else begin
            // Outside prescaling the phase output is held low
            cpu_clk_phase_out <= 1'b0;
        end
    end

    // APB slave: one wait-free access phase, error on unmapped address
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr[7:0])
            ADDR_CFG_UPPER: next_prdata = {24'h00_0000, reset_pin_config_upper};
            ADDR_RST_CTRL:  next_prdata = {16'h0000, reset_control_reg};
            ADDR_STATUS:    next_prdata = {27'h000_0000, direct_drive_out, prescale_out,
                                           pll_enable_out, long_reset, hw_reset_in};
            default:        next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addr_ok;
            if (rd_access) begin
                prdata <= next_prdata;
            end
        end
    end

    // Configuration register sources
    chk_reload_loads: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (reload_req && !long_reset) |=> reset_pin_config_upper == $past(reset_control_reg[15:8]))
        else $error("reload did not copy reset control upper half");

    chk_reload_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !reset_control_reg[0])
        else $error("reload bit did not clear itself");

    chk_long_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        long_reset |=> reset_pin_config_upper == $past(pin_view))
        else $error("long reset did not capture pins");

    chk_long_qualify: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !hw_reset_in |=> !long_reset)
        else $error("long reset flag without hardware reset");

    chk_long_source: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        long_reset |-> $past(hw_reset_in))
        else $error("long reset flag not preceded by hardware reset");

    chk_emul_invert: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (emulation_mode_in || emulation_hold_mode_in) |->
        pin_view[7] != port0_upper_pins_in[7])
        else $error("emulation did not invert field msb pin");

    chk_emul_pass: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(emulation_mode_in || emulation_hold_mode_in) |-> pin_view == port0_upper_pins_in)
        else $error("pins altered outside emulation");

    chk_mode_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ##1 clock_gen_select_out == $past(reset_pin_config_upper[7:5]))
        else $error("mode output does not follow field");

    chk_mode_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!long_reset && !reload_req) |=> $stable(reset_pin_config_upper))
        else $error("config changed without cause");

    // One check per field code against the factor table
    chk_mult_x4: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h7) |-> pll_mult_x2_out == 4'h8)
        else $error("default code not times four");

    chk_mult_x3: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h6) |-> pll_mult_x2_out == 4'h6)
        else $error("code 110 not times three");

    chk_mult_x2: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h5) |-> pll_mult_x2_out == 4'h4)
        else $error("code 101 not times two");

    chk_mult_x5: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h4) |-> pll_mult_x2_out == 4'hA)
        else $error("code 100 not times five");

    chk_mult_x1: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h3) |-> pll_mult_x2_out == 4'h2)
        else $error("code 011 not times one");

    chk_mult_x1p5: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h2) |-> pll_mult_x2_out == 4'h3)
        else $error("code 010 not times one and a half");

    chk_mult_div2: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h1) |-> pll_mult_x2_out == 4'h1)
        else $error("code 001 not divide by two");

    chk_mult_x2p5: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h0) |-> pll_mult_x2_out == 4'h5)
        else $error("code 000 not times two and a half");

    // Exactly one clock path is selected
    chk_pll_path: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pll_enable_out |-> !direct_drive_out && !prescale_out
        && clock_gen_select_out != 3'h1 && clock_gen_select_out != 3'h3)
        else $error("pll enabled outside pll mode");

    chk_pll_on: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out != 3'h1 && clock_gen_select_out != 3'h3) |-> pll_enable_out)
        else $error("pll not enabled in pll mode");

    chk_one_path: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $onehot({pll_enable_out, prescale_out, direct_drive_out}))
        else $error("clock path selection not one hot");

    chk_prescale_code: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        prescale_out == (clock_gen_select_out == 3'h1))
        else $error("prescaler enable does not match code 001");

    chk_direct_code: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        direct_drive_out == (clock_gen_select_out == 3'h3))
        else $error("direct drive does not match code 011");

    chk_direct_nopll: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clock_gen_select_out == 3'h3) |-> direct_drive_out && !pll_enable_out)
        else $error("direct mode with pll enabled");

    chk_prescale_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (prescale_out && $past(prescale_out)) |-> cpu_clk_phase_out != $past(cpu_clk_phase_out))
        else $error("prescaler phase did not toggle");

    chk_half_period: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        prescale_out |=> cpu_clk_phase_out != $past(cpu_clk_phase_out))
        else $error("prescaled half period longer than one oscillator period");

    chk_direct_phase: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !prescale_out |=> !cpu_clk_phase_out)
        else $error("phase output active outside prescaler mode");

    // Register bus answers one cycle after setup, for one cycle only
    chk_setup_ready: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (psel && !penable) |=> pready)
        else $error("no ready one cycle after setup");

    chk_ready_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

endmodule : ccms_clock_select
`default_nettype wire

// >>> shared/ccms_pkg.sv
// Package with register map, field layout and clock mode encodings
package ccms_pkg;
    localparam logic [7:0]  ADDR_CFG_UPPER   = 8'h00;
    localparam logic [7:0]  ADDR_RST_CTRL    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS      = 8'h08;
    localparam int          CLK_FIELD_MSB    = 7;
    localparam int          CLK_FIELD_LSB    = 5;
    localparam int          RST_CTRL_UP_LSB  = 8;
    localparam int          RELOAD_BIT       = 0;
    localparam logic [7:0]  CFG_RESET_VALUE  = 8'hE0;
    localparam logic [15:0] RST_CTRL_RESET   = 16'h0000;
    localparam logic [2:0]  MODE_X4          = 3'h7;
    localparam logic [2:0]  MODE_X3          = 3'h6;
    localparam logic [2:0]  MODE_X2          = 3'h5;
    localparam logic [2:0]  MODE_X5          = 3'h4;
    localparam logic [2:0]  MODE_DIRECT      = 3'h3;
    localparam logic [2:0]  MODE_X1P5        = 3'h2;
    localparam logic [2:0]  MODE_PRESCALE    = 3'h1;
    localparam logic [2:0]  MODE_X2P5        = 3'h0;
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          LONG_RESET_NS    = 1000;
    localparam int          LONG_RESET_CYC   = (LONG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {CCMS_PLL, CCMS_PRESCALE, CCMS_DIRECT} ccms_path_e;
endpackage : ccms_pkg

// >>> sim/ccms_osc_model.sv
// Oscillator model that drives the block's clock input
`timescale 1ns/1ps
`default_nettype none
module ccms_osc_model #(
    parameter int HALF_NS = 50
) (
    output logic osc_out
);
    initial osc_out = 1'b0;
    always #(HALF_NS) osc_out = ~osc_out;
endmodule : ccms_osc_model
`default_nettype wire

// >>> sim/tb_cpu_clock_mode_select.sv
// Testbench for the CPU clock mode selection block
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_clock_mode_select;
    import ccms_pkg::*;
    localparam int LRC = 2;
    logic        clk_in, sys_rst_in, hw_reset, emu, emu_hold, b, err;
    logic        psel, penable, pwrite, pready, pslverr, pll_en, pre, dir, phase;
    logic [7:0]  pins, p;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [2:0]  sel;
    logic [3:0]  mult;
    int          fails, total_checks;
    int          cyc = 0;

    ccms_osc_model u_ccms_osc_model (.osc_out(clk_in));
    ccms_clock_select #(.LONG_RESET_CYCLES(LRC)) u_ccms_clock_select (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hw_reset_in(hw_reset),
        .emulation_mode_in(emu), .emulation_hold_mode_in(emu_hold), .port0_upper_pins_in(pins),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_gen_select_out(sel),
        .pll_enable_out(pll_en), .pll_mult_x2_out(mult), .prescale_out(pre),
        .direct_drive_out(dir), .cpu_clk_phase_out(phase));

    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // Setup then access phase, held until pready is sampled high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task lreset(input logic [7:0] v, input logic em, input logic eh);
        @(posedge clk_in);
        pins <= v;
        emu <= em;
        emu_hold <= eh;
        hw_reset <= 1'b1;
        repeat (LRC + 3) @(posedge clk_in);
        hw_reset <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : lreset

    // Factor times two for each field code
    function automatic logic [3:0] exp_mult(input logic [2:0] c);
        case (c)
            3'h7:    return 4'h8;
            3'h6:    return 4'h6;
            3'h5:    return 4'h4;
            3'h4:    return 4'hA;
            3'h3:    return 4'h2;
            3'h2:    return 4'h3;
            3'h1:    return 4'h1;
            default: return 4'h5;
        endcase
    endfunction : exp_mult

    // Expected decode of a clock field
    task outs(input logic [2:0] c);
        chk(32'(sel), 32'(c));
        chk(32'(mult), 32'(exp_mult(c)));
        chk(32'(pll_en), 32'(c != 3'h1 && c != 3'h3));
        chk(32'(pre), 32'(c == 3'h1));
        chk(32'(dir), 32'(c == 3'h3));
        if (c != 3'h1)
            chk(32'(phase), 32'h0000_0000);
    endtask : outs

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        sys_rst_in = 1'b1;
        hw_reset = 1'b0;
        emu = 1'b0;
        emu_hold = 1'b0;
        pins = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fails = 0;
        total_checks = 0;
        void'($urandom(42));
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        outs(3'h7);
        apb(1'b0, 32'(ADDR_CFG_UPPER), '0);
        chk(rd, 32'(CFG_RESET_VALUE));
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            p = {c[2:0], 5'($urandom)};
            lreset(p, 1'b0, 1'b0);
            apb(1'b0, 32'(ADDR_CFG_UPPER), '0);
            chk(rd, 32'(p));
            outs(c[2:0]);
        end
        pins <= ~p;
        hw_reset <= 1'b1;
        @(posedge clk_in);
        hw_reset <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(32'(sel), 32'(p[7:5]));
        $display("capture test done");
        lreset(8'h20, 1'b1, 1'b0);
        chk(32'(sel), 32'h0000_0005);
        lreset(8'hE0, 1'b0, 1'b1);
        chk(32'(sel), 32'h0000_0003);
        $display("emulation test done");
        p = {3'h1, 5'($urandom)};
        apb(1'b1, 32'(ADDR_RST_CTRL), {16'h0000, p, 8'h00});
        apb(1'b1, 32'(ADDR_RST_CTRL), {16'h0000, p, 8'h01});
        apb(1'b1, 32'(ADDR_CFG_UPPER), 32'h0000_00FF);
        apb(1'b0, 32'(ADDR_CFG_UPPER), '0);
        chk(rd, 32'(p));
        apb(1'b0, 32'(ADDR_RST_CTRL), '0);
        chk(rd, {16'h0000, p, 8'h00});
        apb(1'b0, 32'(ADDR_STATUS), '0);
        chk(rd, 32'h0000_0008);
        outs(3'h1);
        repeat (6) begin
            b = phase;
            @(posedge clk_in);
            chk(32'(phase), 32'(!b));
        end
        $display("reload test done");
        apb(1'b0, 32'h0000_000C, '0);
        chk({rd[30:0], err}, 32'h0000_0001);
        $display("unmapped test done");
        final_report();
    end
endmodule : tb_cpu_clock_mode_select
`default_nettype wire
